// [rtl/dcfpc_top.sv]
// Port control, FIFO array, mailboxes and retransmit of the two-port FIFO
//
// What this block does
// - Port-B mailbox write drives b-to-a flag low
// - Port-A mailbox read returns b-to-a flag high
// - Reset sets b-to-a flag high
// - Output-ready registered; low blocks FIFO reads
// - Output-ready high means valid output word
// - Output-ready low in reset, rises third edge
// - Rewind reloads read pointer from mark
// - Offset selects captured at reset release
// - Retransmit select with ready marks word
// - Mark kept until retransmit select low
// - Port-A bus released while direction high
// - Port-B bus released while direction low
// - Operation needs chip select low, enable high
// - Port-A mailbox select routes to mailbox
// - A-to-b flag low on write, high on read
// - Input-ready low when full or reset
`timescale 1ns/1ps
`include "dcfpc_cfg.svh"
`default_nettype none
module dcfpc_top (
   input wire logic i_clk_sys,
   input wire logic i_rstn,
   input wire dcfpc_pkg::dcfpc_port_t i_port_a,
   input wire dcfpc_pkg::dcfpc_port_t i_port_b,
   input wire logic i_retransmit_mode_select,
   input wire logic i_rewind_to_mark,
   input wire logic i_offset_select_0,
   input wire logic i_offset_select_1,
   input wire logic [`DCFPC_RAW-1:0] i_reg_addr,
   input wire logic [31:0] i_reg_wdata,
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   output logic [31:0] o_reg_rdata,
   output logic [`DCFPC_DW-1:0] o_port_a_data,
   output logic o_port_a_data_oe,
   output logic [`DCFPC_DW-1:0] o_port_b_data,
   output logic o_port_b_data_oe,
   output logic o_input_ready_flag,
   output logic o_output_ready_flag,
   output logic o_a_to_b_mail_flag,
   output logic o_b_to_a_mail_flag,
   output logic [1:0] o_offset_method
);
   import dcfpc_pkg::*;

   // ==========================================================
   // Port decode
   logic a_op, a_wr, a_rd, a_fifo_wr, a_mail_wr, a_mail_rd;
   logic b_op, b_wr, b_rd, b_fifo_rd, b_mail_wr, b_mail_rd;
   logic retx_allow;

   assign a_op = ~i_port_a.cs_n & i_port_a.en;
   assign a_wr = a_op & i_port_a.dir;
   assign a_rd = a_op & ~i_port_a.dir;
   assign a_fifo_wr = a_wr & ~i_port_a.mbox & o_input_ready_flag;
   assign a_mail_wr = a_wr & i_port_a.mbox;
   assign a_mail_rd = a_rd & i_port_a.mbox;
   assign b_op = ~i_port_b.cs_n & i_port_b.en;
   assign b_wr = b_op & ~i_port_b.dir;
   assign b_rd = b_op & i_port_b.dir;
   assign b_fifo_rd = b_rd & ~i_port_b.mbox & o_output_ready_flag;
   assign b_mail_wr = b_wr & i_port_b.mbox;
   assign b_mail_rd = b_rd & i_port_b.mbox;

   // ==========================================================
   // FIFO array and write side
   logic [`DCFPC_DW-1:0] mem [0:`DCFPC_DEPTH-1];
   logic [`DCFPC_PW-1:0] wr_ptr, wr_s1, wr_s2, rd_ptr, out_addr, mark_ptr;
   logic [`DCFPC_PW-1:0] next_wr_ptr, free_ptr, used;
   dcfpc_rt_state_t rt_state;

   assign next_wr_ptr = a_fifo_wr ? wr_ptr + `DCFPC_PTR_ONE : wr_ptr;
   // Marked data must not be overwritten while retransmit is armed
   assign free_ptr = (rt_state == DCFPC_RETX) ? mark_ptr : rd_ptr;
   assign used = next_wr_ptr - free_ptr;

   always_ff @(posedge i_clk_sys) begin
      if (a_fifo_wr) begin
         mem[wr_ptr[`DCFPC_AW-1:0]] <= i_port_a.data;
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (!i_rstn) begin
         wr_ptr <= `DCFPC_PTR_ZERO;
         o_input_ready_flag <= 1'b0;
      end else begin
         wr_ptr <= next_wr_ptr;
         o_input_ready_flag <= (used != `DCFPC_DEPTH);
      end
   end

   // Two-stage lag of the write pointer seen by the read side
   always_ff @(posedge i_clk_sys) begin
      if (!i_rstn) begin
         wr_s1 <= `DCFPC_PTR_ZERO;
         wr_s2 <= `DCFPC_PTR_ZERO;
      end else begin
         wr_s1 <= wr_ptr;
         wr_s2 <= wr_s1;
      end
   end

   // ==========================================================
   // Read side and output register
   logic avail, load, rewind;
   logic [`DCFPC_DW-1:0] out_word;

   assign avail = (wr_s2 != rd_ptr);
   assign load = avail & (~o_output_ready_flag | b_fifo_rd);
   assign rewind = (rt_state == DCFPC_RETX) & i_rewind_to_mark & b_op;

   always_ff @(posedge i_clk_sys) begin
      if (!i_rstn) begin
         rd_ptr <= `DCFPC_PTR_ZERO;
         out_addr <= `DCFPC_PTR_ZERO;
         out_word <= `DCFPC_DATA_ZERO;
         o_output_ready_flag <= 1'b0;
      end else if (rewind) begin
         out_word <= mem[mark_ptr[`DCFPC_AW-1:0]];
         out_addr <= mark_ptr;
         rd_ptr <= mark_ptr + `DCFPC_PTR_ONE;
         o_output_ready_flag <= 1'b1;
      end else if (load) begin
         out_word <= mem[rd_ptr[`DCFPC_AW-1:0]];
         out_addr <= rd_ptr;
         rd_ptr <= rd_ptr + `DCFPC_PTR_ONE;
         o_output_ready_flag <= 1'b1;
      end else if (b_fifo_rd) begin
         o_output_ready_flag <= 1'b0;
      end
   end

   // ==========================================================
   // Retransmit mode
   always_ff @(posedge i_clk_sys) begin
      if (!i_rstn) begin
         rt_state <= DCFPC_FWD;
         mark_ptr <= `DCFPC_PTR_ZERO;
      end else begin
         unique case (rt_state)
            DCFPC_FWD: begin
               if (i_retransmit_mode_select && o_output_ready_flag && retx_allow) begin
                  rt_state <= DCFPC_RETX;
                  mark_ptr <= out_addr;
               end
            end
            DCFPC_RETX: begin
               if (!i_retransmit_mode_select) begin
                  rt_state <= DCFPC_FWD;
               end
            end
            default: begin
               rt_state <= DCFPC_FWD;
            end
         endcase
      end
   end

   // ==========================================================
   // Mailboxes; a write in the same edge as a read wins
   logic [`DCFPC_DW-1:0] mail_a2b, mail_b2a;

   always_ff @(posedge i_clk_sys) begin
      if (!i_rstn) begin
         mail_a2b <= `DCFPC_DATA_ZERO;
         o_a_to_b_mail_flag <= 1'b1;
      end else if (a_mail_wr) begin
         mail_a2b <= i_port_a.data;
         o_a_to_b_mail_flag <= 1'b0;
      end else if (b_mail_rd) begin
         o_a_to_b_mail_flag <= 1'b1;
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (!i_rstn) begin
         mail_b2a <= `DCFPC_DATA_ZERO;
         o_b_to_a_mail_flag <= 1'b1;
      end else if (b_mail_wr) begin
         mail_b2a <= i_port_b.data;
         o_b_to_a_mail_flag <= 1'b0;
      end else if (a_mail_rd) begin
         o_b_to_a_mail_flag <= 1'b1;
      end
   end

   // ==========================================================
   // Port data drivers
   always_ff @(posedge i_clk_sys) begin
      if (!i_rstn) begin
         o_port_a_data <= `DCFPC_DATA_ZERO;
      end else if (a_mail_rd) begin
         o_port_a_data <= mail_b2a;
      end
   end

   assign o_port_a_data_oe = ~i_port_a.cs_n & ~i_port_a.dir;
   assign o_port_b_data_oe = ~i_port_b.cs_n & i_port_b.dir;
   assign o_port_b_data = i_port_b.mbox ? mail_a2b : out_word;

   // ==========================================================
   // Offset method capture at reset release
   logic rst_q;

   always_ff @(posedge i_clk_sys) begin
      if (!i_rstn) begin
         rst_q <= 1'b0;
      end else begin
         rst_q <= 1'b1;
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (!rst_q && i_rstn) begin
         o_offset_method <= {i_offset_select_1, i_offset_select_0};
      end
   end

   // ==========================================================
   // Register port
   always_ff @(posedge i_clk_sys) begin
      if (!i_rstn) begin
         retx_allow <= `DCFPC_CTRL_RST;
      end else if (i_reg_wr && i_reg_addr == `DCFPC_REG_CTRL) begin
         retx_allow <= i_reg_wdata[0];
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (!i_rstn || !i_reg_rd) begin
         o_reg_rdata <= `DCFPC_WORD_ZERO;
      end else if (i_reg_addr == `DCFPC_REG_STATUS) begin
         o_reg_rdata <= {25'h0, o_offset_method, rt_state == DCFPC_RETX, o_input_ready_flag,
                         o_output_ready_flag, o_a_to_b_mail_flag, o_b_to_a_mail_flag};
      end else if (i_reg_addr == `DCFPC_REG_CTRL) begin
         o_reg_rdata <= {31'h0, retx_allow};
      end else begin
         o_reg_rdata <= `DCFPC_WORD_ZERO;
      end
   end

   // ==========================================================
   // Assertions
   property p_b2a_low;
      @(posedge i_clk_sys) disable iff (!i_rstn) b_mail_wr |=> !o_b_to_a_mail_flag;
   endproperty
   a_b2a_low: assert property (p_b2a_low) else $error("b-to-a flag not low");

   property p_b2a_high;
      @(posedge i_clk_sys) disable iff (!i_rstn)
         a_mail_rd && !b_mail_wr |=> o_b_to_a_mail_flag;
   endproperty
   a_b2a_high: assert property (p_b2a_high) else $error("b-to-a flag not high");

   property p_after_reset;
      @(posedge i_clk_sys) disable iff (!i_rstn)
         !rst_q |-> o_b_to_a_mail_flag && o_a_to_b_mail_flag && !o_output_ready_flag;
   endproperty
   a_after_reset: assert property (p_after_reset) else $error("bad flags after reset");

   property p_or_third;
      @(posedge i_clk_sys) disable iff (!i_rstn)
         a_fifo_wr && !o_output_ready_flag && rt_state == DCFPC_FWD && wr_ptr == rd_ptr
         && wr_s1 == rd_ptr && wr_s2 == rd_ptr
         |-> ##1 (!o_output_ready_flag)[*3] ##1 o_output_ready_flag;
   endproperty
   a_or_third: assert property (p_or_third) else $error("output-ready not on third edge");

   property p_empty_read;
      @(posedge i_clk_sys) disable iff (!i_rstn)
         b_fifo_rd && !avail && !rewind |=> !o_output_ready_flag;
   endproperty
   a_empty_read: assert property (p_empty_read) else $error("output-ready stuck high");

   property p_rewind;
      @(posedge i_clk_sys) disable iff (!i_rstn)
         rewind |=> o_output_ready_flag && out_addr == $past(mark_ptr)
         && rd_ptr == $past(mark_ptr) + `DCFPC_PTR_ONE;
   endproperty
   a_rewind: assert property (p_rewind) else $error("rewind did not reload mark");

   property p_mark;
      @(posedge i_clk_sys) disable iff (!i_rstn)
         rt_state == DCFPC_FWD && i_retransmit_mode_select && o_output_ready_flag && retx_allow
         |=> rt_state == DCFPC_RETX && mark_ptr == $past(out_addr);
   endproperty
   a_mark: assert property (p_mark) else $error("retransmit mark not taken");

   property p_mark_hold;
      @(posedge i_clk_sys) disable iff (!i_rstn)
         rt_state == DCFPC_RETX && i_retransmit_mode_select
         |=> rt_state == DCFPC_RETX && $stable(mark_ptr);
   endproperty
   a_mark_hold: assert property (p_mark_hold) else $error("mark lost in retransmit");

   property p_a_release;
      @(posedge i_clk_sys) disable iff (!i_rstn) i_port_a.dir |-> !o_port_a_data_oe;
   endproperty
   a_a_release: assert property (p_a_release) else $error("port A driven on write");

   property p_b_release;
      @(posedge i_clk_sys) disable iff (!i_rstn) !i_port_b.dir |-> !o_port_b_data_oe;
   endproperty
   a_b_release: assert property (p_b_release) else $error("port B driven on write");

   property p_a2b;
      @(posedge i_clk_sys) disable iff (!i_rstn)
         a_mail_wr |=> !o_a_to_b_mail_flag && mail_a2b == $past(i_port_a.data);
   endproperty
   a_a2b: assert property (p_a2b) else $error("a-to-b mailbox write failed");

   property p_offset;
      @(posedge i_clk_sys) disable iff (!i_rstn)
         rst_q && !$past(rst_q) |-> o_offset_method == $past({i_offset_select_1, i_offset_select_0});
   endproperty
   a_offset: assert property (p_offset) else $error("offset method not captured");
endmodule : dcfpc_top
`default_nettype wire

// [shared/dcfpc_cfg.svh]
// Constants for the dual-clock FIFO port control block
`ifndef DCFPC_CFG_SVH
`define DCFPC_CFG_SVH
`define DCFPC_DW 36
`define DCFPC_AW 9
`define DCFPC_PW 10
`define DCFPC_DEPTH 10'h200
`define DCFPC_PTR_ZERO 10'h000
`define DCFPC_PTR_ONE 10'h001
`define DCFPC_DATA_ZERO 36'h0_0000_0000
`define DCFPC_RAW 4
`define DCFPC_REG_STATUS 4'h0
`define DCFPC_REG_CTRL 4'h4
`define DCFPC_CTRL_RST 1'h1
`define DCFPC_WORD_ZERO 32'h0000_0000
`endif

// [shared/dcfpc_pkg.sv]
// Types shared by the dual-clock FIFO port control block
`default_nettype none
package dcfpc_pkg;
   // One port's control and write data as sampled on a clock edge
   typedef struct packed {
      logic cs_n;
      logic en;
      logic dir;
      logic mbox;
      logic [35:0] data;
   } dcfpc_port_t;

   typedef enum logic [1:0] {
      DCFPC_FWD = 2'h1,
      DCFPC_RETX = 2'h2
   } dcfpc_rt_state_t;
endpackage : dcfpc_pkg
`default_nettype wire

// [dv/dcfpc_port_master.sv]
// Bus masters that stand on port A and port B of the FIFO block
`timescale 1ns/1ps
`default_nettype none
module dcfpc_port_master (
   input wire logic i_clk_sys,
   output var dcfpc_pkg::dcfpc_port_t o_port_a,
   output var dcfpc_pkg::dcfpc_port_t o_port_b
);
   import dcfpc_pkg::*;
   initial begin
      o_port_a = '{1'h1, 1'h0, 1'h1, 1'h0, 36'h0_0000_0000};
      o_port_b = '{1'h1, 1'h0, 1'h0, 1'h0, 36'h0_0000_0000};
   end
   // One port-A operation on one edge; released data shows its inverse
   task automatic a_op(input logic dir, input logic mbox, input logic [35:0] d);
      @(posedge i_clk_sys);
      o_port_a <= '{1'h0, 1'h1, dir, mbox, d};
      @(posedge i_clk_sys);
      o_port_a <= '{1'h1, 1'h0, dir, 1'h0, ~d};
      #1;
   endtask : a_op
   task automatic b_op(input logic dir, input logic mbox, input logic [35:0] d);
      @(posedge i_clk_sys);
      o_port_b <= '{1'h0, 1'h1, dir, mbox, d};
      @(posedge i_clk_sys);
      o_port_b <= '{1'h1, 1'h0, dir, 1'h0, ~d};
      #1;
   endtask : b_op
endmodule : dcfpc_port_master
`default_nettype wire

// [dv/dcfpc_top_tb.sv]
// Self-checking testbench of the FIFO port control block
`timescale 1ns/1ps
`default_nettype none
module dcfpc_top_tb;
   import dcfpc_pkg::*;
   logic i_clk_sys = 1'h0;
   logic i_rstn = 1'h0;
   logic rt_sel = 1'h0, rew = 1'h0, fs0 = 1'h0, fs1 = 1'h1, wr = 1'h0, rd = 1'h0;
   logic [3:0] addr = 4'h0;
   logic [31:0] wdata = 32'h0000_0000, rdata;
   logic [35:0] a_data, b_data;
   logic a_oe, b_oe, in_rdy, out_rdy, ab_flag, ba_flag;
   logic [1:0] method;
   dcfpc_port_t port_a, port_b;
   int n_fail = 0, compares = 0, n;
   always #2.5 i_clk_sys = ~i_clk_sys;
   dcfpc_port_master i_dcfpc_port_master (.i_clk_sys(i_clk_sys), .o_port_a(port_a),
      .o_port_b(port_b));
   dcfpc_top i_dcfpc_top (.i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .i_port_a(port_a),
      .i_port_b(port_b), .i_retransmit_mode_select(rt_sel), .i_rewind_to_mark(rew),
      .i_offset_select_0(fs0), .i_offset_select_1(fs1), .i_reg_addr(addr),
      .i_reg_wdata(wdata), .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdata),
      .o_port_a_data(a_data), .o_port_a_data_oe(a_oe), .o_port_b_data(b_data),
      .o_port_b_data_oe(b_oe), .o_input_ready_flag(in_rdy),
      .o_output_ready_flag(out_rdy), .o_a_to_b_mail_flag(ab_flag),
      .o_b_to_a_mail_flag(ba_flag), .o_offset_method(method));
   task automatic give_verdict();
      $display("compares %0d n_fail %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : give_verdict
   task automatic chk(input string nm, input logic [35:0] exp, input logic [35:0] got);
      compares++;
      if (got !== exp) begin
         n_fail++;
         $display("MISMATCH %s exp %h got %h", nm, exp, got);
      end
   endtask : chk
   // Register write then read, data checked in the cycle after the read
   task automatic reg_acc(input logic [3:0] a, input logic [31:0] wd, input logic [31:0] exp);
      @(posedge i_clk_sys);
      addr <= a;
      wr <= 1'h1;
      wdata <= wd;
      @(posedge i_clk_sys);
      wr <= 1'h0;
      rd <= 1'h1;
      @(posedge i_clk_sys);
      rd <= 1'h0;
      #1;
      chk("rdata", {4'h0, exp}, {4'h0, rdata});
   endtask : reg_acc
   // Port operation with output enable looked at while the request stands
   task automatic mop(input logic b, input logic dir, input logic mbox, input logic [35:0] d,
         input logic oe_exp);
      fork
         if (b) i_dcfpc_port_master.b_op(dir, mbox, d);
         else i_dcfpc_port_master.a_op(dir, mbox, d);
         begin
            repeat (2) @(negedge i_clk_sys);
            chk("oe", {35'h0, oe_exp}, {35'h0, b ? b_oe : a_oe});
         end
      join
   endtask : mop
   task automatic t_reset();
      repeat (5) @(posedge i_clk_sys);
      i_rstn <= 1'h1;
      #1;
      chk("flags in reset", 36'h3, {32'h0, in_rdy, out_rdy, ab_flag, ba_flag});
      @(posedge i_clk_sys);
      fs1 <= 1'h0;
      fs0 <= 1'h1;
      repeat (2) @(posedge i_clk_sys);
      #1;
      chk("method", 36'h2, {34'h0, method});
      chk("in ready", 36'h1, {35'h0, in_rdy});
      reg_acc(4'h0, 32'hFFFF_FFFF, 32'h0000_004B);
      reg_acc(4'h8, 32'hFFFF_FFFF, 32'h0000_0000);
      reg_acc(4'h4, 32'h0000_0000, 32'h0000_0000);
      reg_acc(4'h4, 32'h0000_0001, 32'h0000_0001);
   endtask : t_reset
   task automatic t_mail();
      mop(1'h1, 1'h0, 1'h1, 36'hA_5A5A_5A5A, 1'h0);
      chk("b to a flag", 36'h0, {35'h0, ba_flag});
      mop(1'h0, 1'h0, 1'h1, 36'h0_0000_0000, 1'h1);
      chk("b to a flag", 36'h1, {35'h0, ba_flag});
      chk("a data", 36'hA_5A5A_5A5A, a_data);
      mop(1'h0, 1'h1, 1'h1, 36'h3_C3C3_C3C3, 1'h0);
      chk("a to b flag", 36'h0, {35'h0, ab_flag});
      mop(1'h1, 1'h1, 1'h1, 36'h0_0000_0000, 1'h1);
      chk("a to b flag", 36'h1, {35'h0, ab_flag});
      // Mailbox word shown on port B while the mailbox read stands
      fork
         i_dcfpc_port_master.b_op(1'h1, 1'h1, 36'h0_0000_0000);
         begin
            repeat (2) @(negedge i_clk_sys);
            chk("b mail data", 36'h3_C3C3_C3C3, b_data);
         end
      join
   endtask : t_mail
   task automatic t_fifo();
      mop(1'h0, 1'h1, 1'h0, 36'h1_2345_6789, 1'h0);
      for (n = 1; n < 9 && out_rdy !== 1'h1; n++) begin
         @(posedge i_clk_sys);
         #1;
      end
      if (n == 9) begin
         n_fail++;
         give_verdict();
      end
      chk("ready edges", 36'h4, n);
      chk("b data", 36'h1_2345_6789, b_data);
      i_dcfpc_port_master.a_op(1'h1, 1'h0, 36'hF_EDCB_A987);
      repeat (4) @(posedge i_clk_sys);
      rt_sel <= 1'h1;
      i_dcfpc_port_master.b_op(1'h1, 1'h0, 36'h0_0000_0000);
      repeat (4) @(posedge i_clk_sys);
      #1;
      chk("b data", 36'hF_EDCB_A987, b_data);
      @(posedge i_clk_sys);
      rew <= 1'h1;
      i_dcfpc_port_master.b_op(1'h1, 1'h0, 36'h0_0000_0000);
      @(posedge i_clk_sys);
      rew <= 1'h0;
      repeat (3) @(posedge i_clk_sys);
      #1;
      chk("b data rewound", 36'h1_2345_6789, b_data);
      chk("out ready", 36'h1, {35'h0, out_rdy});
      i_dcfpc_port_master.b_op(1'h1, 1'h0, 36'h0_0000_0000);
      @(posedge i_clk_sys);
      rt_sel <= 1'h0;
      repeat (4) @(posedge i_clk_sys);
      #1;
      chk("b data after mark", 36'hF_EDCB_A987, b_data);
      // Rewind after exit must not reload; the empty read drops ready
      @(posedge i_clk_sys);
      rew <= 1'h1;
      i_dcfpc_port_master.b_op(1'h1, 1'h0, 36'h0_0000_0000);
      @(posedge i_clk_sys);
      rew <= 1'h0;
      #1;
      chk("out ready after exit", 36'h0, {35'h0, out_rdy});
   endtask : t_fifo
   // Fill until input-ready drops: array depth plus the output register word
   task automatic t_full();
      for (n = 0; n < 600 && in_rdy === 1'h1; n++) begin
         i_dcfpc_port_master.a_op(1'h1, 1'h0, 36'(n));
      end
      if (n == 600) begin
         n_fail++;
         give_verdict();
      end
      chk("writes until full", 36'h201, n);
      chk("in ready full", 36'h0, {35'h0, in_rdy});
      i_dcfpc_port_master.b_op(1'h1, 1'h0, 36'h0_0000_0000);
      @(posedge i_clk_sys);
      #1;
      chk("in ready after read", 36'h1, {35'h0, in_rdy});
   endtask : t_full
   initial begin
      t_reset();
      t_mail();
      t_fifo();
      t_full();
      give_verdict();
   end
   initial begin
      #200000;
      n_fail++;
      give_verdict();
   end
endmodule : dcfpc_top_tb
`default_nettype wire
